// File: src/pfsel_defines.svh
// Constants for the port 1 pin-function select block.
// Assumes an 8-bit register port addressed by 16-bit byte addresses.
//
// Summary of operation
// - Reset, hardware standby reload 0x87; software standby keeps it.
// - Pin-control bits 7 and 2..0 ignore writes and read as one.
// - Interrupt-1 enable makes pin 6 its input; data read shows pin.
// - Interrupt-0 enable makes pin 5 its input; data read shows pin.
// - Edge-select bit: zero picks falling edge, one picks rising edge.
// - Bus release acts in expanded mode only; else pins 2, 3 plain.
// - Bus release: pin 3 request input, pin 2 acknowledge output.
// - Pin 7 carries timer output when any output-select bit is set.
// - Pin 6 feeds interrupt-1, converter trigger, or both, else plain I/O.
// - Expanded with wait select one: pin 4 is the wait-request input.
// - Pins 1 and 0 output E clock and system clock when direction set.
// - Direction bit one makes the pin an output, zero an input.
// - Data read returns driven value for output pins, live level for inputs.
`ifndef PFSEL_DEFINES_SVH
`define PFSEL_DEFINES_SVH

`define PFSEL_ADDR_DIR 16'hfe80
`define PFSEL_ADDR_DATA 16'hfe82
`define PFSEL_ADDR_SYSPIN 16'hfefc

`define PFSEL_SYSPIN_RESET 8'h87
`define PFSEL_SYSPIN_FIXED 8'h87
`define PFSEL_DIR_RESET 8'h03
`define PFSEL_DIR_STANDBY 8'h00
`define PFSEL_DATA_RESET 8'h00

`define PFSEL_BIT_IRQ_ONE_EN 6
`define PFSEL_BIT_IRQ_ZERO_EN 5
`define PFSEL_BIT_EDGE_SEL 4
`define PFSEL_BIT_BUS_REL 3

`endif

// File: src/pfsel_pkg.sv
// Types for the port 1 pin-function select block.
// Assumes the constants header is included by the users.
package pfsel_pkg;
   // Function driving a pin output
   typedef enum logic [2:0] {
      PFSEL_SRC_LATCH,
      PFSEL_SRC_TIMER,
      PFSEL_SRC_BACK,
      PFSEL_SRC_ECLK,
      PFSEL_SRC_SCLK
   } pfsel_src_type;
endpackage : pfsel_pkg

// File: src/pfsel_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps
module pfsel_sync #(
   parameter logic INIT = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_d,
   output logic o_q
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic q_r;

   // Shift chain; first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
      end else begin
         s1_r <= i_d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a change once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_r <= INIT;
      end else if (s2_r == s3_r) begin
         q_r <= s3_r;
      end
   end

   assign o_q = q_r;
endmodule : pfsel_sync

// File: src/pfsel_nmi_edge.sv
// Edge detector for the nonmaskable interrupt pin.
// Assumes a synchronised level at its input.
`timescale 1ns/1ps
module pfsel_nmi_edge (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_level,
   input wire logic i_rising,
   output logic o_pulse
);
   logic prev_r;

   // Previous level, reset to idle high
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= i_level;
      end
   end

   assign o_pulse = i_rising ? (i_level & ~prev_r) : (~i_level & prev_r);

   // Assertions on the edge pulse
   a_nmi_fall: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_rising && $fell(i_level)) |-> o_pulse)
      else $error("falling edge missed");
   a_nmi_rise: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rising && $rose(i_level)) |-> o_pulse)
      else $error("rising edge missed");
   a_nmi_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
      $stable(i_level) |-> !o_pulse)
      else $error("pulse without edge");
endmodule : pfsel_nmi_edge

// File: src/pfsel_port1.sv
// Port 1 pin-function select: registers, pin muxing, peripheral taps.
// Assumes CPU register port on i_clk, pins as in/out/enable triples,
// peripheral control bits supplied by their owning units.
//
// Chosen here: strobed register access.
`include "pfsel_defines.svh"
`timescale 1ns/1ps
module pfsel_port1 (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_hw_standby,
   input wire logic i_expanded,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_pin,
   output logic [7:0] o_pin,
   output logic [7:0] o_pin_oe,
   input wire logic i_nmi_pin,
   output logic o_nmi_pulse,
   output logic o_nmi_rising,
   input wire logic [3:0] i_timer_output_select,
   input wire logic i_timer8_output,
   input wire logic i_converter_trigger_enable,
   input wire logic i_wait_mode_select_one,
   input wire logic i_bus_ack,
   input wire logic i_e_clock,
   input wire logic i_sys_clock,
   output logic o_ext_interrupt_one,
   output logic o_ext_interrupt_zero,
   output logic o_converter_trigger_in,
   output logic o_wait_request,
   output logic o_bus_request_in
);
   ////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] system_pin_control_r;
   logic [7:0] port_direction_reg_r;
   logic [7:0] port_data_reg_r;
   logic [7:0] rdata_r;
   logic [7:0] pin_sync;
   logic nmi_sync;
   logic irq_one_enable;
   logic irq_zero_enable;
   logic nmi_edge_select;
   logic bus_release_enable;
   logic bus_rel_active;
   logic timer_active;
   logic wait_active;
   logic wr_sys;
   logic wr_dir;
   logic wr_data;
   pfsel_pkg::pfsel_src_type src [8];

   // Writes act on the next edge
   assign wr_sys = i_wr && (i_addr == `PFSEL_ADDR_SYSPIN);
   assign wr_dir = i_wr && (i_addr == `PFSEL_ADDR_DIR);
   assign wr_data = i_wr && (i_addr == `PFSEL_ADDR_DATA);

   // Reset and hardware standby load, written on wr_sys, held otherwise
   always_ff @(posedge i_clk) begin
      if (i_rst || i_hw_standby) begin
         system_pin_control_r <= `PFSEL_SYSPIN_RESET;
      end else if (wr_sys) begin
         system_pin_control_r <= i_wdata | `PFSEL_SYSPIN_FIXED;
      end
   end

   // Direction register; cleared in hardware standby
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         port_direction_reg_r <= `PFSEL_DIR_RESET;
      end else if (i_hw_standby) begin
         port_direction_reg_r <= `PFSEL_DIR_STANDBY;
      end else if (wr_dir) begin
         port_direction_reg_r <= i_wdata;
      end
   end

   // Data latch; bits 1 and 0 are read-only
   always_ff @(posedge i_clk) begin
      if (i_rst || i_hw_standby) begin
         port_data_reg_r <= `PFSEL_DATA_RESET;
      end else if (wr_data) begin
         port_data_reg_r <= {i_wdata[7:2], 2'b00};
      end
   end

   assign irq_one_enable = system_pin_control_r[`PFSEL_BIT_IRQ_ONE_EN];
   assign irq_zero_enable = system_pin_control_r[`PFSEL_BIT_IRQ_ZERO_EN];
   assign nmi_edge_select = system_pin_control_r[`PFSEL_BIT_EDGE_SEL];
   assign bus_release_enable = system_pin_control_r[`PFSEL_BIT_BUS_REL];

   ////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_sync
         pfsel_sync #(.INIT(1'b0)) u_sync (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_d(i_pin[g]),
            .o_q(pin_sync[g])
         );
      end
   endgenerate

   pfsel_sync #(.INIT(1'b1)) u_nmi_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(i_nmi_pin),
      .o_q(nmi_sync)
   );

   pfsel_nmi_edge u_nmi (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(nmi_sync),
      .i_rising(nmi_edge_select),
      .o_pulse(o_nmi_pulse)
   );
   assign o_nmi_rising = nmi_edge_select;

   ////////////////////////////////////////////////////////////////////
   // Function selection
   // Bus release only counts in expanded mode
   assign bus_rel_active = i_expanded && bus_release_enable;
   // Any output-select bit hands pin 7 to the timer
   assign timer_active = |i_timer_output_select;
   // Wait input in expanded mode only
   assign wait_active = i_expanded && i_wait_mode_select_one;

   // Output enables per pin
   always_comb begin
      o_pin_oe = port_direction_reg_r;
      // Timer drives pin 7 whatever the direction
      if (timer_active) begin
         o_pin_oe[7] = 1'b1;
      end
      // Interrupt-1 forces pin 6 to input
      if (irq_one_enable || i_converter_trigger_enable) begin
         o_pin_oe[6] = 1'b0;
      end
      // Interrupt-0 forces pin 5 to input
      if (irq_zero_enable) begin
         o_pin_oe[5] = 1'b0;
      end
      // Wait request forces pin 4 to input
      if (wait_active) begin
         o_pin_oe[4] = 1'b0;
      end
      if (bus_rel_active) begin
         o_pin_oe[3] = 1'b0;
         o_pin_oe[2] = 1'b1;
      end
   end

   // Output source per pin
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         src[i] = pfsel_pkg::PFSEL_SRC_LATCH;
      end
      if (timer_active) begin
         src[7] = pfsel_pkg::PFSEL_SRC_TIMER;
      end
      if (bus_rel_active) begin
         src[2] = pfsel_pkg::PFSEL_SRC_BACK;
      end
      // Clock outputs on pins 1 and 0
      src[1] = pfsel_pkg::PFSEL_SRC_ECLK;
      src[0] = pfsel_pkg::PFSEL_SRC_SCLK;
   end

   // Output data mux
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         case (src[i])
            pfsel_pkg::PFSEL_SRC_TIMER: o_pin[i] = i_timer8_output;
            pfsel_pkg::PFSEL_SRC_BACK: o_pin[i] = i_bus_ack;
            pfsel_pkg::PFSEL_SRC_ECLK: o_pin[i] = i_e_clock;
            pfsel_pkg::PFSEL_SRC_SCLK: o_pin[i] = i_sys_clock;
            default: o_pin[i] = port_data_reg_r[i];
         endcase
      end
   end

   // Peripheral input taps, gated by their selection
   // Pin 6 feeds one or both functions
   assign o_ext_interrupt_one = irq_one_enable & pin_sync[6];
   assign o_converter_trigger_in = i_converter_trigger_enable & pin_sync[6];
   assign o_ext_interrupt_zero = irq_zero_enable & pin_sync[5];
   assign o_wait_request = wait_active & pin_sync[4];
   assign o_bus_request_in = bus_rel_active & pin_sync[3];

   ////////////////////////////////////////////////////////////////////
   // Register read port, data one cycle after strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_r <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `PFSEL_ADDR_SYSPIN: rdata_r <= system_pin_control_r;
            `PFSEL_ADDR_DIR: rdata_r <= 8'hff;
            // Driven value for outputs, live pin for inputs
            `PFSEL_ADDR_DATA: rdata_r <= (o_pin_oe & o_pin)
               | (~o_pin_oe & pin_sync);
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign o_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_sys_reset: assert property (@(posedge i_clk)
      (i_rst || i_hw_standby) |=> system_pin_control_r == 8'h87)
      else $error("pin-control not reloaded");
   a_fixed_ones: assert property (@(posedge i_clk) disable iff (i_rst)
      (system_pin_control_r & 8'h87) == 8'h87)
      else $error("fixed bits not one");
   a_pin6_input: assert property (@(posedge i_clk) disable iff (i_rst)
      irq_one_enable |-> !o_pin_oe[6])
      else $error("pin 6 driven with ext_interrupt_one");
   a_pin5_input: assert property (@(posedge i_clk) disable iff (i_rst)
      irq_zero_enable |-> !o_pin_oe[5])
      else $error("pin 5 driven with ext_interrupt_zero");
   a_single_chip: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_expanded |-> o_pin_oe[3:2] == port_direction_reg_r[3:2])
      else $error("bus release in single-chip");
   a_bus_ack: assert property (@(posedge i_clk) disable iff (i_rst)
      bus_rel_active |-> o_pin_oe[2] && o_pin[2] == i_bus_ack)
      else $error("acknowledge not driven");
   a_timer_pin: assert property (@(posedge i_clk) disable iff (i_rst)
      timer_active |-> o_pin_oe[7] && o_pin[7] == i_timer8_output)
      else $error("timer output missing");
   a_wait_pin: assert property (@(posedge i_clk) disable iff (i_rst)
      wait_active |-> o_wait_request == pin_sync[4])
      else $error("wait request wrong");
   a_clk_out: assert property (@(posedge i_clk) disable iff (i_rst)
      o_pin[0] == i_sys_clock && o_pin[1] == i_e_clock)
      else $error("clock outputs wrong");
   sequence s_sys_write;
      wr_sys && !i_hw_standby;
   endsequence
   a_sel_next: assert property (@(posedge i_clk) disable iff (i_rst)
      s_sys_write |=> irq_one_enable == $past(i_wdata[6]))
      else $error("selection not applied next cycle");
   a_read_input: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == `PFSEL_ADDR_DATA && !o_pin_oe[4])
      |=> o_rdata[4] == $past(pin_sync[4]))
      else $error("input pin read wrong");

   ////////////////////////////////////////////////////////////////////
   // Register state checks

   // Direction reset leaves both clock pins driving
   a_dir_reset: assert property (@(posedge i_clk)
      i_rst |=> port_direction_reg_r == 8'h03)
      else $error("direction reset value wrong");

   // Hardware standby clears every direction bit
   a_dir_standby: assert property (@(posedge i_clk)
      (!i_rst && i_hw_standby) |=> port_direction_reg_r == 8'h00)
      else $error("direction not cleared in standby");

   // Pin-control holds without a write or standby
   a_sys_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_hw_standby && !wr_sys) |=> $stable(system_pin_control_r))
      else $error("pin-control changed unasked");

   ////////////////////////////////////////////////////////////////////
   // Pin function checks

   // Request pin held as input under bus release
   a_pin3_input: assert property (@(posedge i_clk) disable iff (i_rst)
      bus_rel_active |-> !o_pin_oe[3])
      else $error("pin 3 driven with bus release");

   // Request tap follows the synchronised pin
   a_bus_request_in_tap: assert property (@(posedge i_clk) disable iff (i_rst)
      bus_rel_active |-> o_bus_request_in == pin_sync[3])
      else $error("bus request tap wrong");

   // No request without expanded-mode release
   a_no_bus_request_in: assert property (@(posedge i_clk) disable iff (i_rst)
      !bus_rel_active |-> !o_bus_request_in)
      else $error("bus request outside release");

   // Pin 7 back under its direction bit
   a_timer_off: assert property (@(posedge i_clk) disable iff (i_rst)
      !timer_active |-> o_pin_oe[7] == port_direction_reg_r[7])
      else $error("pin 7 direction ignored");

   // Trigger use holds pin 6 as input
   a_trig_tap: assert property (@(posedge i_clk) disable iff (i_rst)
      i_converter_trigger_enable
      |-> !o_pin_oe[6] && o_converter_trigger_in == pin_sync[6])
      else $error("converter trigger tap wrong");

   // Pin 6 plain when neither function picked
   a_pin6_plain: assert property (@(posedge i_clk) disable iff (i_rst)
      (!irq_one_enable && !i_converter_trigger_enable)
      |-> o_pin_oe[6] == port_direction_reg_r[6])
      else $error("pin 6 direction ignored");

   // Interrupt-1 tap follows the synchronised pin
   a_ext_interrupt_one_tap: assert property (@(posedge i_clk) disable iff (i_rst)
      irq_one_enable |-> o_ext_interrupt_one == pin_sync[6])
      else $error("interrupt 1 tap wrong");

   // Pin 5 plain and quiet without interrupt-0
   a_pin5_plain: assert property (@(posedge i_clk) disable iff (i_rst)
      !irq_zero_enable
      |-> o_pin_oe[5] == port_direction_reg_r[5]
         && !o_ext_interrupt_zero)
      else $error("pin 5 plain use wrong");

   // Pin 4 plain and quiet without wait select
   a_wait_plain: assert property (@(posedge i_clk) disable iff (i_rst)
      !wait_active
      |-> o_pin_oe[4] == port_direction_reg_r[4]
         && !o_wait_request)
      else $error("pin 4 plain use wrong");

   // Clock pins follow their direction bits
   a_dir_follow: assert property (@(posedge i_clk) disable iff (i_rst)
      o_pin_oe[1:0] == port_direction_reg_r[1:0])
      else $error("clock pin direction wrong");

   ////////////////////////////////////////////////////////////////////
   // Read port checks
   sequence s_data_read;
      i_rd && i_addr == `PFSEL_ADDR_DATA;
   endsequence

   // Output pin reads back its driven value
   a_read_output: assert property (@(posedge i_clk) disable iff (i_rst)
      (s_data_read ##0 o_pin_oe[7]) |=> o_rdata[7] == $past(o_pin[7]))
      else $error("output pin read wrong");

   // Direction register reads as all ones
   a_dir_readback: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == `PFSEL_ADDR_DIR) |=> o_rdata == 8'hff)
      else $error("direction read not all ones");

   // Read data stand one cycle only
   a_read_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_rd |=> o_rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule : pfsel_port1

// File: testbench/pfsel_board.sv
// Board model: external pin drivers and clock sources.
// Assumes pin out/enable pairs from the port, levels from the bench.
`timescale 1ns/1ps
module pfsel_board (
   input wire logic i_clk,
   input wire logic [7:0] i_ext,
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe,
   output logic [7:0] o_pin_level,
   output logic o_e_clock,
   output logic o_sys_clock
);
   // Wire level: port where it drives, board elsewhere
   assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
   // Clock sources for the two clock pins
   initial begin
      o_e_clock = 1'b0;
      o_sys_clock = 1'b0;
   end
   always @(posedge i_clk) begin
      o_sys_clock <= ~o_sys_clock;
      if (o_sys_clock) begin
         o_e_clock <= ~o_e_clock;
      end
   end
endmodule : pfsel_board

// File: testbench/testbench.sv
// Self-checking bench for the port 1 pin-function select block.
// Assumes the board model drives pins and clock sources.
`include "pfsel_defines.svh"
`timescale 1ns/1ps
module testbench;
   logic i_clk, i_rst, i_hw_standby, i_expanded, i_wr, i_rd, i_nmi_pin;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, o_rdata, i_pin, o_pin, o_pin_oe, ext, v, n;
   logic [3:0] i_timer_output_select;
   logic i_timer8_output, i_converter_trigger_enable;
   logic i_wait_mode_select_one, i_bus_ack, i_e_clock, i_sys_clock;
   logic o_nmi_pulse, o_nmi_rising, o_ext_interrupt_one;
   logic o_ext_interrupt_zero, o_converter_trigger_in;
   logic o_wait_request, o_bus_request_in;
   int n_fail, checked;
   localparam logic [15:0] a_sp = `PFSEL_ADDR_SYSPIN;
   localparam logic [15:0] a_dir = `PFSEL_ADDR_DIR;
   localparam logic [15:0] a_dat = `PFSEL_ADDR_DATA;

   pfsel_port1 DUT (.i_clk, .i_rst, .i_hw_standby, .i_expanded, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pin, .o_pin, .o_pin_oe,
      .i_nmi_pin, .o_nmi_pulse, .o_nmi_rising, .i_timer_output_select,
      .i_timer8_output, .i_converter_trigger_enable,
      .i_wait_mode_select_one, .i_bus_ack, .i_e_clock, .i_sys_clock,
      .o_ext_interrupt_one, .o_ext_interrupt_zero, .o_converter_trigger_in,
      .o_wait_request, .o_bus_request_in);
   pfsel_board board (.i_clk(i_clk), .i_ext(ext), .i_pin_out(o_pin),
      .i_pin_oe(o_pin_oe), .o_pin_level(i_pin), .o_e_clock(i_e_clock),
      .o_sys_clock(i_sys_clock));

   // Clock, 5 ns period
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   ////////////////////////////////////////////////////////////////////
   // Shared bus, wait and compare tasks
   task automatic close_out();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic hold(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask : hold
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] r);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      r = o_rdata;
   endtask : rd
   // Edge on the nmi pin, pulses counted over 8 cycles
   task automatic nmi(input logic l, output logic [7:0] c);
      @(posedge i_clk);
      i_nmi_pin <= l;
      c = 8'h00;
      repeat (8) begin
         hold(1);
         c = c + {7'h00, o_nmi_pulse};
      end
   endtask : nmi
   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      rd(a_sp, v);
      chk(v, 8'h87);
      wr(a_sp, 8'h00);
      rd(a_sp, v);
      chk(v, 8'h87);
      wr(a_sp, 8'h78);
      rd(a_sp, v);
      chk(v, 8'hff);
      rd(16'hfe90, v);
      chk(v, 8'h00);
      @(posedge i_clk);
      i_hw_standby <= 1'b1;
      hold(1);
      i_hw_standby <= 1'b0;
      rd(a_sp, v);
      chk(v, 8'h87);
      chk(o_pin_oe, 8'h00);
   endtask : t_regs
   task automatic t_dir();
      wr(a_dir, 8'hff);
      wr(a_dat, 8'ha4);
      chk(o_pin_oe, 8'hff);
      chk({o_pin[7:2], 2'b00}, 8'ha4);
      chk({6'h00, o_pin[1:0]}, {6'h00, i_e_clock, i_sys_clock});
      rd(a_dat, v);
      chk(v & 8'hfc, 8'ha4);
      rd(a_dir, v);
      chk(v, 8'hff);
      wr(a_dir, 8'h00);
      ext <= 8'h5a;
      chk(o_pin_oe, 8'h00);
      hold(6);
      rd(a_dat, v);
      chk(v, 8'h5a);
   endtask : t_dir
   task automatic t_irq();
      wr(a_dir, 8'hff);
      wr(a_sp, 8'h60);
      chk(o_pin_oe, 8'h9f);
      ext <= 8'h40;
      hold(6);
      chk({6'h00, o_ext_interrupt_one, o_ext_interrupt_zero}, 8'h02);
      rd(a_dat, v);
      chk(v & 8'h60, 8'h40);
      ext <= 8'h20;
      hold(6);
      chk({6'h00, o_ext_interrupt_one, o_ext_interrupt_zero}, 8'h01);
      rd(a_dat, v);
      chk(v & 8'h60, 8'h20);
      wr(a_sp, 8'h00);
      chk(o_pin_oe, 8'hff);
      chk({6'h00, o_ext_interrupt_one, o_ext_interrupt_zero}, 8'h00);
   endtask : t_irq
   task automatic t_nmi();
      wr(a_sp, 8'h10);
      chk({7'h00, o_nmi_rising}, 8'h01);
      nmi(1'b0, n);
      chk(n, 8'h00);
      nmi(1'b1, n);
      chk(n, 8'h01);
      wr(a_sp, 8'h00);
      nmi(1'b0, n);
      chk(n, 8'h01);
      nmi(1'b1, n);
      chk(n, 8'h00);
   endtask : t_nmi
   task automatic t_bus();
      wr(a_sp, 8'h08);
      chk(o_pin_oe, 8'hff);
      @(posedge i_clk);
      i_expanded <= 1'b1;
      i_bus_ack <= 1'b1;
      ext <= 8'h18;
      hold(6);
      chk(o_pin_oe, 8'he7);
      chk(o_pin & 8'h04, 8'h04);
      chk({6'h00, o_bus_request_in, o_wait_request}, 8'h03);
      @(posedge i_clk);
      i_bus_ack <= 1'b0;
      i_wait_mode_select_one <= 1'b0;
      hold(1);
      chk(o_pin & 8'h04, 8'h00);
      chk(o_pin_oe, 8'hf7);
      wr(a_sp, 8'h87);
      chk(o_pin_oe, 8'hff);
      i_expanded <= 1'b0;
   endtask : t_bus
   task automatic t_tmr();
      wr(a_dir, 8'h00);
      ext <= 8'h40;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         i_timer_output_select <= 4'h1 << i;
         i_timer8_output <= i[0];
         hold(1);
         chk(o_pin_oe, 8'h80);
         chk(o_pin & 8'h80, {i[0], 7'h00});
      end
      @(posedge i_clk);
      i_timer_output_select <= 4'h0;
      i_converter_trigger_enable <= 1'b1;
      hold(6);
      chk(o_pin_oe, 8'h00);
      chk({6'h00, o_converter_trigger_in, o_ext_interrupt_one}, 8'h02);
      wr(a_sp, 8'hc7);
      chk({6'h00, o_converter_trigger_in, o_ext_interrupt_one}, 8'h03);
      i_converter_trigger_enable <= 1'b0;
      hold(1);
      chk({6'h00, o_converter_trigger_in, o_ext_interrupt_one}, 8'h01);
   endtask : t_tmr
   ////////////////////////////////////////////////////////////////////
   // Main sequence and hang guard
   initial begin
      i_rst = 1'b1;
      i_hw_standby = 1'b0;
      i_expanded = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 8'h00;
      i_nmi_pin = 1'b1;
      ext = 8'h00;
      i_timer_output_select = 4'h0;
      i_timer8_output = 1'b0;
      i_converter_trigger_enable = 1'b0;
      i_wait_mode_select_one = 1'b1;
      i_bus_ack = 1'b0;
      n_fail = 0;
      checked = 0;
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      t_dir();
      t_irq();
      t_nmi();
      t_bus();
      t_tmr();
      close_out();
   end
   initial begin
      #200000;
      n_fail++;
      close_out();
   end
endmodule : testbench
